// ---- rtl/sfc_params.svh ----
// shared constants for the serial flash command front end
// How it works
// R1: reset pin low aborts work, returns idle
// R2: stay reset while pin low, resume after
// R3: internal power-on reset, pin level irrelevant
// R4: host drives reset pin high when idle
// R5: ready/busy pulled low during self-timed work
// R6: busy refuses array and used buffer
// R7: mode 3 assumed after power-up or reset
// R8: output off; chip-select fall needed first
// R9: chip-select fall samples clock idle level
// R10: continuous read is 68h or e8h
// R11: page read is 52h or d2h
// R12: buffer read is 54h or d4h
// R13: status read is 57h or d7h
// R14: buffer write 84h, erases 81h, 50h
// R15: program with erase is 83h
// R16: program without erase is 88h
// R17: write-then-program through buffer is 82h
// R18: capture on rising, shift out on falling
// R19: chip-select frames each operation; deselected is quiet
// R20: protect pin low guards lowest 256 pages
// R21: unknown opcode ignored until deselect
// R22: opcode msb first, decoded at bit eight
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
`define SFC_OP_CAR_IP 8'h68
`define SFC_OP_CAR_SPI 8'he8
`define SFC_OP_MPR_IP 8'h52
`define SFC_OP_MPR_SPI 8'hd2
`define SFC_OP_BFR_IP 8'h54
`define SFC_OP_BFR_SPI 8'hd4
`define SFC_OP_STR_IP 8'h57
`define SFC_OP_STR_SPI 8'hd7
`define SFC_OP_BFW 8'h84
`define SFC_OP_PGE 8'h81
`define SFC_OP_BLE 8'h50
`define SFC_OP_PGM_ER 8'h83
`define SFC_OP_PGM_NE 8'h88
`define SFC_OP_PGM_THR 8'h82
`define SFC_OPC_LAST 16'h0007
`define SFC_HDR_BITS 16'h0020
`define SFC_STAT_START 16'h0008
`define SFC_BRD_START 16'h0028
`define SFC_ARD_START 16'h0040
`define SFC_PA_MSB 17
`define SFC_PA_LSB 9
`define SFC_PROT_PAGES 9'h100
`define SFC_BUF_BYTES 9'h108
`define SFC_ERASED 8'hff
`define SFC_RST_MODE_HI 1'b1
`define SFC_CLK_NS 100
`define SFC_SCK_HALF_NS 800
`define SFC_SCK_HALF_CYC ((`SFC_SCK_HALF_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`endif

// ---- rtl/sfc_pkg.sv ----
// types shared by both ends of the serial flash link
`default_nettype none
package sfc_pkg;
   typedef enum logic [1:0] {
      SFC_H_IDLE = 2'h0,
      SFC_H_LEAD = 2'h1,
      SFC_H_XFER = 2'h3,
      SFC_H_TAIL = 2'h2
   } sfc_hstate_t;
   typedef enum logic [2:0] {
      SFC_C_NONE = 3'h0,
      SFC_C_STAT = 3'h1,
      SFC_C_BRD = 3'h3,
      SFC_C_ARD = 3'h2,
      SFC_C_BWR = 3'h6,
      SFC_C_PTB = 3'h7,
      SFC_C_PROG = 3'h5,
      SFC_C_ERASE = 3'h4
   } sfc_cmd_t;
endpackage : sfc_pkg
`default_nettype wire

// ---- rtl/sfc_if.sv ----
// serial flash link wires with one modport per end
`timescale 1ns/1ps
`default_nettype none
interface sfc_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so_out;
   logic so_oe;
   logic rb_oe;
   logic rst_pin_n;
   logic wp_n;
   logic so_line;
   logic rb_line;
   // undriven lines read as pulled high
   assign so_line = so_oe ? so_out : 1'b1;
   assign rb_line = ~rb_oe;
   modport dev (input cs_n, sck, si, rst_pin_n, wp_n, output so_out, so_oe, rb_oe);
   modport host (output cs_n, sck, si, rst_pin_n, wp_n, input so_line, rb_line);
endinterface : sfc_if
`default_nettype wire

// ---- rtl/sfc_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   // first stage feeds only the second stage
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         meta_reg <= INIT;
         q <= INIT;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : sfc_sync
`default_nettype wire

// ---- rtl/sfc_dev.sv ----
// flash end: reset, mode detect, opcode decode, busy and buffer
`timescale 1ns/1ps
`default_nettype none
`include "sfc_params.svh"
module sfc_dev import sfc_pkg::*; #(
   parameter int BUSY_PROG_CYC = 2000,
   parameter int BUSY_ERASE_CYC = 1000,
   parameter logic [3:0] STAT_ID = 4'h5 // arbitrary value
) (
   input wire logic core_clk,
   input wire logic rst_n,
   sfc_if.dev lnk,
   output logic busy,
   output logic mode_hi,
   output logic op_valid,
   output logic [7:0] op_code,
   output logic wp_reject
);
   logic [4:0] sync_q;
   logic cs_s;
   logic sck_s;
   logic si_s;
   logic rpin_s;
   logic wp_s;
   logic dev_rst;
   logic cs_d_reg;
   logic sck_d_reg;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic sel_reg;
   logic [15:0] cnt_reg;
   logic [7:0] sh_reg;
   logic [23:0] addr_reg;
   sfc_cmd_t cmd_reg;
   logic [8:0] ptr_reg;
   logic [15:0] busy_cnt_reg;
   logic bbuf_reg;
   logic [7:0] buf_mem [0:`SFC_BUF_BYTES-1];
   logic [7:0] new_byte;
   logic [15:0] out_start;
   logic [7:0] out_byte;
   logic is_write;
   logic byte_done;
   logic prot_hit;

   // pins cross into the core clock; reset pin idles high
   sfc_sync #(.W(5), .INIT(5'h1b)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .d({lnk.cs_n, lnk.sck, lnk.si, lnk.rst_pin_n, lnk.wp_n}),
      .q(sync_q)
   );
   assign cs_s = sync_q[4];
   assign sck_s = sync_q[3];
   assign si_s = sync_q[2];
   assign rpin_s = sync_q[1];
   assign wp_s = sync_q[0];

   // power-on reset or pin reset, held as long as the pin stays low
   assign dev_rst = !rst_n || !rpin_s; // R1 R2 R3

   // edge finder on the synchronised link clock and select
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cs_d_reg <= 1'b1;
         sck_d_reg <= 1'b1;
      end else begin
         cs_d_reg <= cs_s;
         sck_d_reg <= sck_s;
      end
   end
   assign cs_fall = cs_d_reg & ~cs_s;
   assign cs_rise = ~cs_d_reg & cs_s;
   // clock edges count only while selected after a select fall
   assign sck_rise = sel_reg & ~cs_s & ~sck_d_reg & sck_s; // R18 R19
   assign sck_fall = sel_reg & ~cs_s & sck_d_reg & ~sck_s; // R18 R19

   // a frame is only armed by a fresh select fall after reset
   always_ff @(posedge core_clk) begin
      if (dev_rst) begin
         sel_reg <= 1'b0;
      end else if (cs_fall) begin
         sel_reg <= 1'b1; // R8 R19
      end else if (cs_rise) begin
         sel_reg <= 1'b0; // R19
      end
   end

   // clock idle level at select fall picks the mode
   always_ff @(posedge core_clk) begin
      if (dev_rst) begin
         mode_hi <= `SFC_RST_MODE_HI; // R7
      end else if (cs_fall) begin
         mode_hi <= sck_s; // R9
      end
   end

   // opcode and address shift in msb first
   assign new_byte = {sh_reg[6:0], si_s};
   always_ff @(posedge core_clk) begin
      if (dev_rst || cs_fall) begin
         cnt_reg <= 16'h0000;
         sh_reg <= 8'h00;
         addr_reg <= 24'h000000;
      end else if (sck_rise) begin
         cnt_reg <= cnt_reg + 16'h0001;
         sh_reg <= new_byte; // R22
         if (cnt_reg > `SFC_OPC_LAST && cnt_reg < `SFC_HDR_BITS) begin
            addr_reg <= {addr_reg[22:0], si_s};
         end
      end
   end

   // opcode classes; busy work blocks array and its buffer
   function automatic sfc_cmd_t decode(input logic [7:0] op, input logic bsy,
                                       input logic bbuf);
      case (op)
         `SFC_OP_STR_IP, `SFC_OP_STR_SPI: decode = SFC_C_STAT; // R13
         `SFC_OP_BFR_IP, `SFC_OP_BFR_SPI: decode = bbuf ? SFC_C_NONE : SFC_C_BRD; // R12 R6
         `SFC_OP_BFW: decode = bbuf ? SFC_C_NONE : SFC_C_BWR; // R14 R6
         `SFC_OP_CAR_IP, `SFC_OP_CAR_SPI: decode = bsy ? SFC_C_NONE : SFC_C_ARD; // R10 R6
         `SFC_OP_MPR_IP, `SFC_OP_MPR_SPI: decode = bsy ? SFC_C_NONE : SFC_C_ARD; // R11 R6
         `SFC_OP_PGM_ER, `SFC_OP_PGM_NE: decode = bsy ? SFC_C_NONE : SFC_C_PROG; // R15 R16
         `SFC_OP_PGM_THR: decode = bsy ? SFC_C_NONE : SFC_C_PTB; // R17
         `SFC_OP_PGE, `SFC_OP_BLE: decode = bsy ? SFC_C_NONE : SFC_C_ERASE; // R14
         default: decode = SFC_C_NONE; // R21
      endcase
   endfunction : decode

   // decode once the eighth bit lands; unknown stays silent
   always_ff @(posedge core_clk) begin
      if (dev_rst || cs_fall) begin
         cmd_reg <= SFC_C_NONE;
         op_valid <= 1'b0;
         op_code <= 8'h00;
      end else if (sck_rise && cnt_reg == `SFC_OPC_LAST) begin
         cmd_reg <= decode(new_byte, busy, bbuf_reg); // R22
         op_valid <= 1'b1;
         op_code <= new_byte;
      end else begin
         op_valid <= 1'b0;
      end
   end

   // data phase begins after the opcode for status, after header plus dummy bits for reads, right after the header otherwise
   always_comb begin
      case (cmd_reg)
         SFC_C_STAT: out_start = `SFC_STAT_START;
         SFC_C_BRD: out_start = `SFC_BRD_START;
         SFC_C_ARD: out_start = `SFC_ARD_START;
         default: out_start = `SFC_HDR_BITS;
      endcase
   end
   assign is_write = (cmd_reg == SFC_C_BWR) || (cmd_reg == SFC_C_PTB);
   assign byte_done = sck_rise && cnt_reg >= out_start && cnt_reg[2:0] == 3'h7;

   // buffer pointer loads from the byte address and wraps
   always_ff @(posedge core_clk) begin
      if (dev_rst) begin
         ptr_reg <= 9'h000;
      end else if (sck_rise && cnt_reg == `SFC_HDR_BITS - 16'h0001) begin
         ptr_reg <= {addr_reg[7:0], si_s};
      end else if (byte_done && (is_write || cmd_reg == SFC_C_BRD)) begin
         ptr_reg <= (ptr_reg == `SFC_BUF_BYTES - 9'h001) ? 9'h000 : ptr_reg + 9'h001;
      end
   end

   // buffer write stores each whole byte
   always_ff @(posedge core_clk) begin
      if (byte_done && is_write && !dev_rst) begin
         buf_mem[ptr_reg] <= new_byte;
      end
   end

   // output byte for the active read command
   always_comb begin
      case (cmd_reg)
         SFC_C_STAT: out_byte = {~busy, 1'b0, STAT_ID, 2'h0};
         SFC_C_BRD: out_byte = buf_mem[ptr_reg];
         SFC_C_ARD: out_byte = `SFC_ERASED; // array contents not modelled
         default: out_byte = 8'h00;
      endcase
   end

   // serial output moves on falling edges, off when deselected
   always_ff @(posedge core_clk) begin
      if (dev_rst || cs_rise || cs_fall) begin
         lnk.so_oe <= 1'b0; // R8 R19
         lnk.so_out <= 1'b1;
      end else if (sck_fall && cmd_reg inside {SFC_C_STAT, SFC_C_BRD, SFC_C_ARD}
                   && cnt_reg >= out_start) begin
         lnk.so_oe <= 1'b1; // R18 R21
         lnk.so_out <= out_byte[3'h7 - cnt_reg[2:0]];
      end
   end

   // low pages are guarded while the protect pin is low
   // page field sits at its header position once all 24 address bits are in
   assign prot_hit = !wp_s && (addr_reg[`SFC_PA_MSB:`SFC_PA_LSB] < `SFC_PROT_PAGES); // R20

   // self-timed work starts at deselect of a full header
   always_ff @(posedge core_clk) begin
      if (dev_rst) begin
         busy_cnt_reg <= 16'h0000; // R1
         bbuf_reg <= 1'b0;
         busy <= 1'b0;
         wp_reject <= 1'b0;
      end else if (cs_rise && sel_reg && cnt_reg >= `SFC_HDR_BITS
                   && cmd_reg inside {SFC_C_PROG, SFC_C_PTB, SFC_C_ERASE}) begin
         wp_reject <= prot_hit; // R20
         if (!prot_hit) begin
            busy <= 1'b1; // R5
            bbuf_reg <= (cmd_reg != SFC_C_ERASE); // R6
            busy_cnt_reg <= (cmd_reg == SFC_C_ERASE) ? 16'(BUSY_ERASE_CYC)
                                                     : 16'(BUSY_PROG_CYC);
         end
      end else begin
         wp_reject <= 1'b0;
         if (busy_cnt_reg != 16'h0000) begin
            busy_cnt_reg <= busy_cnt_reg - 16'h0001;
            if (busy_cnt_reg == 16'h0001) begin
               busy <= 1'b0; // R5
               bbuf_reg <= 1'b0;
            end
         end
      end
   end

   // ready/busy line driven low while busy
   always_ff @(posedge core_clk) begin
      if (dev_rst) begin
         lnk.rb_oe <= 1'b0;
      end else begin
         lnk.rb_oe <= busy; // R5
      end
   end
endmodule : sfc_dev
`default_nettype wire

// ---- rtl/sfc_host.sv ----
// controller end: builds frames, makes the link clock, reads replies
`timescale 1ns/1ps
`default_nettype none
`include "sfc_params.svh"
module sfc_host import sfc_pkg::*; #(
   parameter int HALF_CYC = `SFC_SCK_HALF_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   sfc_if.host lnk,
   input wire logic cmd_start,
   input wire logic [7:0] cmd_op,
   input wire logic [23:0] cmd_addr,
   input wire logic [8:0] cmd_len,
   input wire logic cmd_mode_hi,
   input wire logic [7:0] wr_byte,
   input wire logic rst_req,
   input wire logic wp_n_in,
   output logic cmd_ready,
   output logic done,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic dev_busy
);
   logic [1:0] sync_q;
   sfc_hstate_t state_reg;
   logic [15:0] tmr_reg;
   logic tick;
   logic [31:0] hdr_reg;
   logic [15:0] hdr_bits_reg;
   logic [15:0] total_reg;
   logic [15:0] cnt_reg;
   logic mode_reg;
   logic rose_reg;
   logic [7:0] rx_sh_reg;
   logic tx_bit;

   sfc_sync #(.W(2), .INIT(2'h3)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .d({lnk.so_line, lnk.rb_line}),
      .q(sync_q)
   );

   // bits before the reply, by opcode
   function automatic logic [15:0] lead_bits(input logic [7:0] op);
      case (op)
         `SFC_OP_STR_IP, `SFC_OP_STR_SPI: lead_bits = `SFC_STAT_START; // R13
         `SFC_OP_BFR_IP, `SFC_OP_BFR_SPI: lead_bits = `SFC_BRD_START; // R12
         `SFC_OP_CAR_IP, `SFC_OP_CAR_SPI, `SFC_OP_MPR_IP, `SFC_OP_MPR_SPI:
            lead_bits = `SFC_ARD_START; // R10 R11
         default: lead_bits = `SFC_HDR_BITS;
      endcase
   endfunction : lead_bits

   assign tick = (tmr_reg == 16'h0000);
   assign tx_bit = (cnt_reg < `SFC_HDR_BITS) ? hdr_reg[5'h1f - cnt_reg[4:0]]
                                             : wr_byte[3'h7 - cnt_reg[2:0]];

   // reset and protect pins follow the user; reset idles high
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lnk.rst_pin_n <= 1'b1;
         lnk.wp_n <= 1'b1;
         dev_busy <= 1'b0;
      end else begin
         lnk.rst_pin_n <= ~rst_req; // R4
         lnk.wp_n <= wp_n_in;
         dev_busy <= ~sync_q[0];
      end
   end

   // frame sequencer; link clock from a half-period divider
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= SFC_H_IDLE;
         lnk.cs_n <= 1'b1;
         lnk.sck <= 1'b1;
         lnk.si <= 1'b0;
         tmr_reg <= 16'h0000;
         hdr_reg <= 32'h00000000;
         hdr_bits_reg <= 16'h0000;
         total_reg <= 16'h0000;
         cnt_reg <= 16'h0000;
         mode_reg <= `SFC_RST_MODE_HI;
         rose_reg <= 1'b0;
         rx_sh_reg <= 8'h00;
         cmd_ready <= 1'b0;
         done <= 1'b0;
         rx_valid <= 1'b0;
         rx_byte <= 8'h00;
      end else begin
         done <= 1'b0;
         rx_valid <= 1'b0;
         tmr_reg <= tick ? 16'(HALF_CYC - 1) : tmr_reg - 16'h0001;
         case (state_reg)
            SFC_H_IDLE: begin
               cmd_ready <= 1'b1;
               if (cmd_start) begin
                  cmd_ready <= 1'b0;
                  hdr_reg <= {cmd_op, cmd_addr};
                  hdr_bits_reg <= lead_bits(cmd_op);
                  total_reg <= lead_bits(cmd_op) + {4'h0, cmd_len, 3'h0};
                  mode_reg <= cmd_mode_hi;
                  lnk.sck <= cmd_mode_hi; // idle level settles before select
                  tmr_reg <= 16'(HALF_CYC - 1);
                  state_reg <= SFC_H_LEAD;
               end
            end
            SFC_H_LEAD: if (tick) begin
               lnk.cs_n <= 1'b0; // R8 R19
               lnk.si <= hdr_reg[31]; // R22
               cnt_reg <= 16'h0000;
               rose_reg <= 1'b0;
               state_reg <= SFC_H_XFER;
            end
            SFC_H_XFER: if (tick) begin
               lnk.sck <= ~lnk.sck;
               if (!lnk.sck) begin
                  // rising edge: device captures, host samples its reply
                  rose_reg <= 1'b1;
                  cnt_reg <= cnt_reg + 16'h0001;
                  rx_sh_reg <= {rx_sh_reg[6:0], sync_q[1]}; // R18
                  if (cnt_reg >= hdr_bits_reg && cnt_reg[2:0] == 3'h7) begin
                     rx_valid <= 1'b1;
                     rx_byte <= {rx_sh_reg[6:0], sync_q[1]};
                  end
                  if (cnt_reg + 16'h0001 >= total_reg) begin
                     state_reg <= SFC_H_TAIL;
                  end
               end else if (rose_reg) begin
                  lnk.si <= tx_bit; // R18
               end
            end
            SFC_H_TAIL: if (tick) begin
               if (lnk.sck != mode_reg) begin
                  lnk.sck <= mode_reg;
               end else begin
                  lnk.cs_n <= 1'b1; // R19
                  done <= 1'b1;
                  state_reg <= SFC_H_IDLE;
               end
            end
            default: state_reg <= SFC_H_IDLE;
         endcase
      end
   end
endmodule : sfc_host
`default_nettype wire

// ---- tb/sfc_props.sv ----
// concurrent checks on the link wires between the host and flash ends
`timescale 1ns/1ps
`default_nettype none
module sfc_props #(
   parameter int BUSY_MAX = 2000
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so_out,
   input wire logic so_oe,
   input wire logic rb_oe,
   input wire logic rst_pin_n,
   input wire logic wp_n,
   input wire logic so_line,
   input wire logic rb_line
);
   int busy_cnt_reg;
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // length of the current busy stretch; a stuck pull-down runs past any program time
   always_ff @(posedge core_clk) begin
      if (!rst_n || !rb_oe) begin
         busy_cnt_reg <= 0;
      end else begin
         busy_cnt_reg <= busy_cnt_reg + 1;
      end
   end
   // deselected, the flash end leaves its reply wire alone; held by the pin, both of its wires
   property p_so_off_deselect;
      cs_n [*8] |-> so_line && !so_oe;
   endproperty
   property p_quiet_pin_reset;
      !rst_pin_n [*5] |-> !so_oe && !rb_oe;
   endproperty
   // no reply enable in the first eight core cycles after a select fall
   property p_so_late_in_frame;
      $fell(cs_n) |-> !so_oe [*8];
   endproperty
   // reply bits only move while the link clock is low
   property p_so_hold_high_sck;
      sck && $past(sck) && so_oe && $past(so_oe) |-> so_out == $past(so_out);
   endproperty
   property p_si_hold_rise;
      !cs_n && $rose(sck) |-> $stable(si) ##1 $stable(si);
   endproperty
   // clock sits at its idle level across both select edges
   property p_cs_fall_sck_idle;
      $fell(cs_n) |-> $stable(sck) ##1 $stable(sck);
   endproperty
   property p_cs_rise_sck_idle;
      $rose(cs_n) |-> $stable(sck);
   endproperty
   property p_busy_outside_frame;
      $fell(rb_line) |-> cs_n;
   endproperty
   property p_busy_bounded;
      busy_cnt_reg <= BUSY_MAX + 8;
   endproperty
   a_so_off_deselect: assert property (p_so_off_deselect) else $error("reply while deselected");
   a_quiet_pin_reset: assert property (p_quiet_pin_reset) else $error("active in pin reset");
   a_so_late_in_frame: assert property (p_so_late_in_frame) else $error("early reply");
   a_so_hold_high_sck: assert property (p_so_hold_high_sck) else $error("reply moved on rise");
   a_si_hold_rise: assert property (p_si_hold_rise) else $error("input moved at rise");
   a_cs_fall_sck_idle: assert property (p_cs_fall_sck_idle) else $error("clock moved at select");
   a_cs_rise_sck_idle: assert property (p_cs_rise_sck_idle) else $error("clock moved at end");
   a_busy_outside_frame: assert property (p_busy_outside_frame) else $error("busy in frame");
   a_busy_bounded: assert property (p_busy_bounded) else $error("busy held too long");
   c_frame: cover property ($fell(cs_n));
   c_busy: cover property ($rose(rb_oe));
   c_reply: cover property ($rose(so_oe));
   c_protect: cover property (!wp_n && $rose(cs_n));
endmodule : sfc_props
`default_nettype wire

// ---- tb/serial_flash_command_frontend_test.sv ----
// self-checking bench: host and flash ends joined across the link
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_frontend_test import sfc_pkg::*; ;
   localparam logic [3:0] ST_ID = 4'ha; // arbitrary value
   localparam int LIMIT = 80000;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_start = 1'b0;
   logic [7:0] cmd_op = 8'h00;
   logic [23:0] cmd_addr = 24'h000000;
   logic [8:0] cmd_len = 9'h000;
   logic cmd_mode_hi = 1'b1;
   logic [7:0] wr_byte = 8'h00;
   logic rst_req = 1'b0;
   logic wp_n_in = 1'b1;
   logic cmd_ready, done, rx_valid, dev_busy, busy, mode_hi, op_valid, wp_reject, so_seen;
   logic [7:0] rx_byte, op_code, got_op;
   logic [7:0] rx_q[$];
   int error_cnt = 0, checks = 0, n_wpr = 0, cyc = 0, seed = 61158;
   logic [7:0] ops[14] = '{8'h68, 8'he8, 8'h52, 8'hd2, 8'h54, 8'hd4, 8'h57, 8'hd7,
                           8'h84, 8'h81, 8'h50, 8'h83, 8'h88, 8'h82};
   always #50 core_clk = ~core_clk;
   sfc_if u_sfc_if ();
   sfc_dev #(.BUSY_PROG_CYC(2000), .BUSY_ERASE_CYC(1000), .STAT_ID(ST_ID)) u_sfc_dev (
      .core_clk(core_clk), .rst_n(rst_n), .lnk(u_sfc_if.dev), .busy(busy), .mode_hi(mode_hi),
      .op_valid(op_valid), .op_code(op_code), .wp_reject(wp_reject));
   sfc_host u_sfc_host (
      .core_clk(core_clk), .rst_n(rst_n), .lnk(u_sfc_if.host), .cmd_start(cmd_start),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_mode_hi(cmd_mode_hi),
      .wr_byte(wr_byte), .rst_req(rst_req), .wp_n_in(wp_n_in), .cmd_ready(cmd_ready),
      .done(done), .rx_valid(rx_valid), .rx_byte(rx_byte), .dev_busy(dev_busy));
   sfc_props #(.BUSY_MAX(2000)) u_sfc_props (
      .core_clk(core_clk), .rst_n(rst_n), .cs_n(u_sfc_if.cs_n), .sck(u_sfc_if.sck),
      .si(u_sfc_if.si), .so_out(u_sfc_if.so_out), .so_oe(u_sfc_if.so_oe),
      .rb_oe(u_sfc_if.rb_oe), .rst_pin_n(u_sfc_if.rst_pin_n), .wp_n(u_sfc_if.wp_n),
      .so_line(u_sfc_if.so_line), .rb_line(u_sfc_if.rb_line));
   function automatic logic [7:0] stat_exp(input logic rdy);
      return {rdy, 1'b0, ST_ID, 2'h0};
   endfunction : stat_exp
   function automatic logic known(input logic [7:0] op);
      foreach (ops[i]) if (ops[i] == op) return 1'b1;
      return 1'b0;
   endfunction : known
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_byte({7'h00, got}, {7'h00, exp}, what);
   endtask : chk_bit
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_cyc
   // the timeout also covers a flash end that never lets go of busy
   task automatic wait_idle();
      while (u_sfc_if.rb_line !== 1'b1) @(posedge core_clk);
      wait_cyc(6);
   endtask : wait_idle
   // one whole frame; settle first so the last reply enable has dropped
   task automatic run(input logic [7:0] op, input logic [23:0] addr, input logic [8:0] len,
                      input logic mh, input logic [7:0] wb);
      wait_cyc(8);
      while (cmd_ready !== 1'b1) @(posedge core_clk);
      rx_q.delete();
      so_seen = 1'b0;
      n_wpr = 0;
      got_op = 8'h00;
      cmd_op <= op;
      cmd_addr <= addr;
      cmd_len <= len;
      cmd_mode_hi <= mh;
      wr_byte <= wb;
      cmd_start <= 1'b1;
      @(posedge core_clk);
      cmd_start <= 1'b0;
      while (done !== 1'b1) @(posedge core_clk);
   endtask : run
   // monitor sees last cycle's settled outputs; also cuts a hang short
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (op_valid === 1'b1) got_op = op_code;
      if (wp_reject === 1'b1) n_wpr = n_wpr + 1;
      if (u_sfc_if.so_oe === 1'b1) so_seen = 1'b1;
      if (rx_valid === 1'b1) rx_q.push_back(rx_byte);
      if (cyc == LIMIT) begin
         error_cnt = error_cnt + 1;
         $display("unexpected at %0t: run did not finish", $time);
         conclude();
      end
   end
   initial begin
      logic [7:0] op, wb;
      logic mh;
      logic [8:0] ba;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      wait_cyc(2);
      chk_bit(u_sfc_if.so_oe, 1'b0, "reply enable after reset");
      chk_bit(mode_hi, 1'b1, "mode after reset");
      chk_bit(u_sfc_if.rb_line, 1'b1, "ready after reset");
      // every opcode in random clock modes, pages above the protected range
      foreach (ops[i]) begin
         mh = 1'($random(seed));
         run(ops[i], {6'h00, 9'h100 | 9'($random(seed)), 9'h000}, 9'h000, mh, 8'h00);
         chk_byte(got_op, ops[i], "decoded opcode");
         chk_bit(mode_hi, mh, "sampled clock mode");
         wait_cyc(10);
         chk_bit(u_sfc_if.rb_line, i < 9, "ready after frame");
         wait_idle();
      end
      for (int k = 0; k < 4; k++) begin
         run(k[0] ? 8'hd7 : 8'h57, 24'h000000, 9'h002, k[1], 8'h00);
         chk_byte(8'(rx_q.size()), 8'h02, "status byte count");
         chk_byte(rx_q[0], stat_exp(1'b1), "status while ready");
      end
      // buffer written then read back in the other clock mode
      for (int k = 0; k < 2; k++) begin
         wb = 8'($random(seed));
         ba = 9'($random(seed)) & 9'h0ff;
         run(8'h84, {15'h0000, ba}, 9'h002, k[0], wb);
         run(k[0] ? 8'h54 : 8'hd4, {15'h0000, ba}, 9'h002, ~k[0], 8'h00);
         chk_byte(rx_q[1], wb, "buffer read back");
      end
      for (int k = 0; k < 3; k++) begin
         op = (k == 0) ? 8'h00 : 8'($random(seed));
         while (known(op)) op = op + 8'h01;
         run(op, 24'h000000, 9'h003, k[0], 8'ha5);
         chk_bit(so_seen, 1'b0, "reply to unknown opcode");
         wait_cyc(10);
         chk_bit(u_sfc_if.rb_line, 1'b1, "ready after unknown opcode");
      end
      // a program locks the buffer but leaves status open
      run(8'h83, {6'h00, 9'h12c, 9'h000}, 9'h000, 1'b1, 8'h00);
      run(8'hd4, {15'h0000, ba}, 9'h001, 1'b1, 8'h00);
      chk_bit(so_seen, 1'b0, "buffer read while programming");
      run(8'hd7, 24'h000000, 9'h001, 1'b0, 8'h00);
      chk_byte(rx_q[0], stat_exp(1'b0), "status while busy");
      // the array stays shut while the program still runs
      run(8'h52, {6'h00, 9'h12c, 9'h000}, 9'h001, 1'b0, 8'h00);
      chk_bit(so_seen, 1'b0, "array read while programming");
      wait_idle();
      // an erase leaves the buffer reachable
      run(8'h81, {6'h00, 9'h12c, 9'h000}, 9'h000, 1'b0, 8'h00);
      run(8'h54, {15'h0000, ba}, 9'h001, 1'b0, 8'h00);
      chk_byte(rx_q[0], wb, "buffer read while erasing");
      chk_bit(u_sfc_if.rb_line, 1'b0, "erase still running");
      chk_bit(dev_busy, 1'b1, "busy seen by host");
      wait_idle();
      // protection boundary: page 255 refused, page 256 programmed
      wp_n_in <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         run(8'h88, {6'h00, k[0] ? 9'h100 : 9'h0ff, 9'h000}, 9'h000, 1'b1, 8'h00);
         wait_cyc(10);
         chk_byte(8'(n_wpr), k[0] ? 8'h00 : 8'h01, "protect refusals");
         chk_bit(u_sfc_if.rb_line, ~k[0], "ready after protected program");
         wait_idle();
      end
      wp_n_in <= 1'b1;
      // reset pin in mid-erase, a frame tried while it is held, then recovery
      run(8'h50, {6'h00, 9'h12c, 9'h000}, 9'h000, 1'b0, 8'h00);
      rst_req <= 1'b1;
      wait_cyc(20);
      chk_bit(u_sfc_if.rb_line, 1'b1, "busy released by reset pin");
      chk_bit(dev_busy, 1'b0, "host sees ready after reset pin");
      chk_bit(mode_hi, 1'b1, "mode after reset pin");
      run(8'hd7, 24'h000000, 9'h001, 1'b0, 8'h00);
      chk_bit(so_seen, 1'b0, "reply while reset pin low");
      chk_bit(busy, 1'b0, "held in reset");
      rst_req <= 1'b0;
      wait_cyc(10);
      run(8'hd7, 24'h000000, 9'h001, 1'b0, 8'h00);
      chk_byte(rx_q[0], stat_exp(1'b1), "status after reset pin");
      conclude();
   end
endmodule : serial_flash_command_frontend_test
`default_nettype wire
